// ### src/eps_defines.svh
// Named constants of the exception priority sequencer.
// Assumes inclusion by bare name from the package and the sequencer.
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH

// ----------------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------------
`define EPS_VEC_POR 8'h00
`define EPS_VEC_MAN_RST 8'h02
`define EPS_VEC_GEN_ILL 8'h04
`define EPS_VEC_SLOT_ILL 8'h06
`define EPS_VEC_CPU_AE 8'h09
`define EPS_VEC_XFER_AE 8'h0A
`define EPS_VEC_NMI 8'h0B
`define EPS_VEC_UBREAK 8'h0C
`define EPS_VEC_TRAP_BASE 8'h20
`define EPS_VEC_IRQ_BASE 8'h40

// ----------------------------------------------------------------------
// Address and mask values
// ----------------------------------------------------------------------
`define EPS_VEC_SHIFT 2
`define EPS_MASK_ALL 4'hF
`define EPS_BASE_RESET 32'h0000_0000
`define EPS_UBREAK_LEVEL 4'hF
`define EPS_TRAP_IDX_W 5

`endif

// ### src/eps_pkg.sv
// Types shared by the exception priority sequencer and its slot checker.
// Assumes the defines header sits beside this file.
`include "eps_defines.svh"

package eps_pkg;

   // Opcode kinds as the pipeline decoder reports them
   typedef enum logic [3:0] {
      OP_OTHER, OP_UNDEF, OP_TRAP,
      OP_JUMP, OP_JUMP_SUB, OP_BRANCH, OP_BRANCH_SUB, OP_RETURN, OP_EXC_RETURN,
      OP_FALSE_DELAYED, OP_TRUE_DELAYED, OP_FAR_SUB_BRANCH, OP_FAR_BRANCH,
      OP_TRUE_BRANCH, OP_FALSE_BRANCH
   } eps_op_e;

   // Exception classes in priority order
   typedef enum logic [2:0] {
      CLS_NONE, CLS_POR, CLS_MAN_RST, CLS_ADDR_ERR, CLS_INTERRUPT, CLS_INSTR
   } eps_cls_e;

   typedef enum logic [1:0] {ST_HOLD, ST_IDLE, ST_WAIT, ST_BUSY} eps_state_e;

   // Start of an exception sequence
   typedef struct packed {
      logic valid;
      eps_cls_e cls;
      logic [7:0] vec;
      logic [31:0] addr;
      logic push_ctx;
      logic mask_load;
      logic [3:0] level;
   } eps_start_s;

   // One acknowledge bit per request source
   typedef struct packed {
      logic cpu_ae;
      logic xfer_ae;
      logic nmi;
      logic ubreak;
      logic [7:0] irq;
      logic per;
   } eps_ack_s;

   // Delayed branches that open a delay slot
   function automatic logic eps_is_delayed(input eps_op_e op);
      eps_is_delayed = op inside {OP_JUMP, OP_JUMP_SUB, OP_BRANCH, OP_BRANCH_SUB,
         OP_RETURN, OP_EXC_RETURN, OP_FALSE_DELAYED, OP_TRUE_DELAYED,
         OP_FAR_SUB_BRANCH, OP_FAR_BRANCH};
   endfunction

   // Everything that rewrites the program counter
   function automatic logic eps_rewrites_pc(input eps_op_e op);
      eps_rewrites_pc = eps_is_delayed(op) ||
         (op inside {OP_TRUE_BRANCH, OP_FALSE_BRANCH, OP_TRAP});
   endfunction

endpackage

// ### src/eps_slot_check.sv
// Delay-slot tracker and instruction-exception classifier.
// Assumes one decode strobe per instruction from the pipeline.
`timescale 1ns/100ps

module eps_slot_check
   import eps_pkg::*;
(
   input wire logic sys_clk_i, // System clock
   input wire logic rst_b_i, // Async reset, active low
   input wire logic dec_valid_i, // Instruction decoded this cycle
   input wire eps_pkg::eps_op_e dec_op_i, // Decoded opcode kind
   input wire logic flush_i, // Exception start flushes slot
   output logic trap_o, // Trap decoded outside a slot
   output logic gen_ill_o, // Undefined code outside a slot
   output logic slot_ill_o // Illegal code inside a slot
);
   import eps_pkg::*;

   typedef struct packed {
      logic in_slot;
   } eps_slot_s;

   eps_slot_s q, d;

   // ---------------------------------------------------------------
   // Classification
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;
      trap_o = dec_valid_i && !q.in_slot && (dec_op_i == OP_TRAP); // RULE9
      gen_ill_o = dec_valid_i && !q.in_slot && (dec_op_i == OP_UNDEF); // RULE10
      slot_ill_o = dec_valid_i && q.in_slot &&
         ((dec_op_i == OP_UNDEF) || eps_rewrites_pc(dec_op_i)); // RULE11 RULE13
      // Delayed branch opens the slot for the next decode
      if (flush_i)
      begin
         d.in_slot = 1'b0;
      end
      else if (dec_valid_i)
      begin
         d.in_slot = !q.in_slot && eps_is_delayed(dec_op_i); // RULE12
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

endmodule // eps_slot_check

// ### src/eps_sequencer.sv
// Exception priority sequencer: arbitrates resets, address errors,
// interrupts and instruction exceptions and times their start.
// Assumes the pipeline reports decode, completion and sequence end,
// and that requesters hold requests until acknowledged.
//
// Behaviour
// (RULE1) Four classes: reset, address, interrupt, instruction
// (RULE2) Simultaneous requests served singly, highest first
// (RULE3) Class order: POR, manual, CPU, transfer, int, instr
// (RULE4) NMI, user break, external, peripheral
// (RULE5) Trap, general illegal, slot illegal
// (RULE6) Power-on reset starts on pin rise
// (RULE7) Manual reset rise with power-on pin high
// (RULE8) Address/interrupt at decode, start after completion
// (RULE9) Trap starts by executing the trap itself
// (RULE10) Undefined code outside slot: general illegal
// (RULE11) Undefined or PC-rewrite in slot: slot illegal
// (RULE12) Ten delayed branches open a delay slot
// (RULE13) Slot-illegal set: delayed, conditional branches, trap
// (RULE14) Address: base plus vector times four; resets unbased
// (RULE15) After reset: base zero, mask all ones
// (RULE16) Push context; only interrupts load mask
// (RULE17) Trap vectors 32-63, external 64-71
// (RULE18) Reset abandons any running sequence at once
// (RULE19) Requesters hold requests until acknowledged
`timescale 1ns/100ps
`include "eps_defines.svh"

module eps_sequencer
   import eps_pkg::*;
(
   input wire logic sys_clk_i, // System clock, 200 MHz
   input wire logic rst_b_i, // Async reset, active low
   input wire logic power_on_reset_pin_b_i, // Power-on reset pin, low active
   input wire logic manual_reset_pin_b_i, // Manual reset pin, low active
   input wire logic dec_valid_i, // Instruction decoded
   input wire eps_pkg::eps_op_e dec_op_i, // Decoded opcode kind
   input wire logic [7:0] dec_imm_i, // Trap immediate
   input wire logic exec_done_i, // Executing instruction finished
   input wire logic seq_done_i, // Pipeline ended exception sequence
   input wire logic cpu_addr_err_i, // CPU address error request
   input wire logic xfer_addr_err_i, // Transfer address error request
   input wire logic nmi_i, // Non-maskable interrupt request
   input wire logic ubreak_i, // User break request
   input wire logic [7:0] irq_i, // External interrupt requests
   input wire logic [7:0][3:0] irq_level_i, // Level of each external request
   input wire logic per_req_i, // Peripheral interrupt request
   input wire logic [3:0] per_level_i, // Peripheral request level
   input wire logic [7:0] per_vec_i, // Peripheral vector number
   input wire logic mask_wr_i, // Software writes mask field
   input wire logic [3:0] mask_wdata_i, // New mask field
   input wire logic base_wr_i, // Software writes vector base
   input wire logic [31:0] base_wdata_i, // New vector base
   output eps_pkg::eps_start_s start_o, // Exception start, one-cycle valid
   output eps_pkg::eps_ack_s ack_o, // Request acknowledges, pulses
   output logic [31:0] vector_base_o, // Vector base register
   output logic [3:0] interrupt_mask_field_o, // Status word mask field
   output logic busy_o // Reset held, exception waiting for completion or sequence running
);
   import eps_pkg::*;

   typedef struct packed {
      eps_state_e st;
      logic [2:0] por_sync;
      logic [2:0] man_sync;
      eps_start_s pend;
      eps_ack_s pend_ack;
      eps_start_s out;
      eps_ack_s ack;
      logic [31:0] base;
      logic [3:0] mask;
      logic busy;
   } eps_top_s;

   eps_top_s q, d;
   logic trap_dec, gen_ill_dec, slot_ill_dec;

   // ---------------------------------------------------------------
   // Instruction classifier
   // ---------------------------------------------------------------
   eps_slot_check u_slot (
      .sys_clk_i (sys_clk_i),
      .rst_b_i (rst_b_i),
      .dec_valid_i (dec_valid_i),
      .dec_op_i (dec_op_i),
      .flush_i (q.out.valid),
      .trap_o (trap_dec),
      .gen_ill_o (gen_ill_dec),
      .slot_ill_o (slot_ill_dec)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Build a start record with its vector table address
   function automatic eps_start_s mk_start(input eps_cls_e cls, input logic [7:0] vec,
                                           input logic [3:0] lvl, input logic [31:0] base);
      logic rst;
      logic [31:0] off;
      rst = (cls == CLS_POR) || (cls == CLS_MAN_RST);
      off = 32'(vec) << `EPS_VEC_SHIFT;
      mk_start.valid = 1'b1;
      mk_start.cls = cls;
      mk_start.vec = vec;
      mk_start.addr = rst ? off : base + off; // RULE14
      mk_start.push_ctx = !rst; // RULE16
      mk_start.mask_load = (cls == CLS_INTERRUPT); // RULE16
      mk_start.level = lvl;
   endfunction

   // Lowest-numbered external request above the mask
   function automatic logic [3:0] pick_irq(input logic [7:0] req,
                                           input logic [7:0][3:0] lvl,
                                           input logic [3:0] mask);
      pick_irq = 4'h8;
      for (int i = 7; i >= 0; i--)
      begin
         if (req[i] && (lvl[i] > mask))
         begin
            pick_irq = 4'(i);
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic por_high, por_rise, man_low, man_rise;
      logic [3:0] irq_sel;
      por_high = 1'b0;
      por_rise = 1'b0;
      man_low = 1'b0;
      man_rise = 1'b0;
      irq_sel = 4'h0;
      d = q;
      d.out = '0;
      d.ack = '0;
      // Pin synchronisers and edge detect on the second stage
      d.por_sync = {q.por_sync[1:0], power_on_reset_pin_b_i};
      d.man_sync = {q.man_sync[1:0], manual_reset_pin_b_i};
      por_high = q.por_sync[1];
      por_rise = q.por_sync[1] && !q.por_sync[2]; // RULE6
      man_low = !q.man_sync[1];
      man_rise = q.man_sync[1] && !q.man_sync[2] && por_high; // RULE7
      irq_sel = pick_irq(irq_i, irq_level_i, q.mask);
      if (!por_high || man_low)
      begin
         d.st = ST_HOLD; // RULE18
         d.busy = 1'b1;
         d.pend = '0;
         d.pend_ack = '0;
      end
      else if (por_rise)
      begin
         d.out = mk_start(CLS_POR, `EPS_VEC_POR, `EPS_MASK_ALL, q.base); // RULE3
         d.st = ST_BUSY;
         d.busy = 1'b1;
      end
      else if (man_rise)
      begin
         d.out = mk_start(CLS_MAN_RST, `EPS_VEC_MAN_RST, `EPS_MASK_ALL, q.base); // RULE3
         d.st = ST_BUSY;
         d.busy = 1'b1;
      end
      else
      begin
         // Software writes to the status mask and vector base
         if (mask_wr_i)
         begin
            d.mask = mask_wdata_i;
         end
         if (base_wr_i)
         begin
            d.base = base_wdata_i;
         end
         unique case (q.st)
            ST_HOLD:
            begin
               d.st = ST_IDLE;
               d.busy = 1'b0;
            end
            ST_IDLE:
            begin
               // Decode-time arbitration, one winner per decode
               if (dec_valid_i) // RULE1 RULE2 RULE8
               begin
                  d.st = ST_WAIT;
                  d.busy = 1'b1;
                  d.pend_ack = '0;
                  if (cpu_addr_err_i) // RULE3
                  begin
                     d.pend = mk_start(CLS_ADDR_ERR, `EPS_VEC_CPU_AE, 4'h0, q.base);
                     d.pend_ack.cpu_ae = 1'b1;
                  end
                  else if (xfer_addr_err_i)
                  begin
                     d.pend = mk_start(CLS_ADDR_ERR, `EPS_VEC_XFER_AE, 4'h0, q.base);
                     d.pend_ack.xfer_ae = 1'b1;
                  end
                  else if (nmi_i) // RULE4
                  begin
                     d.pend = mk_start(CLS_INTERRUPT, `EPS_VEC_NMI, `EPS_MASK_ALL, q.base);
                     d.pend_ack.nmi = 1'b1;
                  end
                  else if (ubreak_i && (`EPS_UBREAK_LEVEL > q.mask)) // RULE4
                  begin
                     d.pend = mk_start(CLS_INTERRUPT, `EPS_VEC_UBREAK, `EPS_UBREAK_LEVEL,
                                       q.base);
                     d.pend_ack.ubreak = 1'b1;
                  end
                  else if (!irq_sel[3]) // RULE4 RULE17
                  begin
                     d.pend = mk_start(CLS_INTERRUPT, `EPS_VEC_IRQ_BASE | {5'h00, irq_sel[2:0]},
                                       irq_level_i[irq_sel[2:0]], q.base);
                     d.pend_ack.irq[irq_sel[2:0]] = 1'b1;
                  end
                  else if (per_req_i && (per_level_i > q.mask)) // RULE4
                  begin
                     d.pend = mk_start(CLS_INTERRUPT, per_vec_i, per_level_i, q.base);
                     d.pend_ack.per = 1'b1;
                  end
                  else if (trap_dec) // RULE5 RULE9 RULE17
                  begin
                     d.pend = mk_start(CLS_INSTR, `EPS_VEC_TRAP_BASE |
                        {3'h0, dec_imm_i[`EPS_TRAP_IDX_W-1:0]}, 4'h0, q.base);
                  end
                  else if (gen_ill_dec) // RULE5 RULE10
                  begin
                     d.out = mk_start(CLS_INSTR, `EPS_VEC_GEN_ILL, 4'h0, q.base);
                     d.st = ST_BUSY;
                  end
                  else if (slot_ill_dec) // RULE5 RULE11
                  begin
                     d.out = mk_start(CLS_INSTR, `EPS_VEC_SLOT_ILL, 4'h0, q.base);
                     d.st = ST_BUSY;
                  end
                  else
                  begin
                     d.st = ST_IDLE;
                     d.busy = 1'b0;
                  end
               end
            end
            ST_WAIT:
            begin
               // Start once the running instruction completes
               if (exec_done_i) // RULE8 RULE19
               begin
                  d.out = q.pend;
                  d.ack = q.pend_ack;
                  d.st = ST_BUSY;
               end
            end
            ST_BUSY:
            begin
               // Sequence end: reset init or interrupt mask load
               if (seq_done_i)
               begin
                  d.st = ST_IDLE;
                  d.busy = 1'b0;
                  if ((q.pend.cls == CLS_POR) || (q.pend.cls == CLS_MAN_RST))
                  begin
                     d.base = `EPS_BASE_RESET; // RULE15
                     d.mask = `EPS_MASK_ALL; // RULE15
                  end
                  else if (q.pend.mask_load)
                  begin
                     d.mask = q.pend.level; // RULE16
                  end
               end
            end
         endcase
      end
      // Remember what was started for the end-of-sequence update
      if (d.out.valid)
      begin
         d.pend = d.out;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign start_o = q.out;
   assign ack_o = q.ack;
   assign vector_base_o = q.base;
   assign interrupt_mask_field_o = q.mask;
   assign busy_o = q.busy;

endmodule // eps_sequencer

// ### verif/eps_checker.sv
// Port checker for the exception priority sequencer.
// Assumes it is bound to every eps_sequencer instance.
`timescale 1ns/100ps

module eps_checker
   import eps_pkg::*;
(
   input wire logic sys_clk_i, // System clock
   input wire logic rst_b_i, // Async reset, active low
   input wire logic power_on_reset_pin_b_i, // Power-on pin
   input wire logic manual_reset_pin_b_i, // Manual pin
   input wire logic dec_valid_i, // Decode strobe
   input wire logic exec_done_i, // Execution finished
   input wire logic seq_done_i, // Sequence finished
   input wire eps_pkg::eps_start_s start_o, // Start record
   input wire eps_pkg::eps_ack_s ack_o, // Acknowledges
   input wire logic [31:0] vector_base_o, // Vector base
   input wire logic [3:0] interrupt_mask_field_o, // Mask field
   input wire logic busy_o // Busy
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   logic rst_q;
   logic int_q;
   logic [3:0] lvl_q;

   // Class and level of the last start
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         rst_q <= 1'b0;
         int_q <= 1'b0;
         lvl_q <= 4'h0;
      end
      else if (start_o.valid)
      begin
         rst_q <= start_o.cls inside {CLS_POR, CLS_MAN_RST};
         int_q <= start_o.cls == CLS_INTERRUPT;
         lvl_q <= start_o.level;
      end

   property p_ack_onehot;
      $onehot0(ack_o) && ((ack_o == '0) || start_o.valid);
   endproperty
   a_ack_onehot: assert property (p_ack_onehot) else $error("ack not single or early");
   property p_reset_addr;
      start_o.valid && start_o.cls inside {CLS_POR, CLS_MAN_RST}
         |-> start_o.addr == {22'h0, start_o.vec, 2'b00};
   endproperty
   a_reset_addr: assert property (p_reset_addr) else $error("reset address wrong");
   property p_based_addr;
      start_o.valid && !(start_o.cls inside {CLS_POR, CLS_MAN_RST})
         |-> start_o.addr == vector_base_o + {22'h0, start_o.vec, 2'b00};
   endproperty
   a_based_addr: assert property (p_based_addr) else $error("based address wrong");
   property p_ctx;
      start_o.valid |-> start_o.mask_load == (start_o.cls == CLS_INTERRUPT)
         && start_o.push_ctx == !(start_o.cls inside {CLS_POR, CLS_MAN_RST});
   endproperty
   a_ctx: assert property (p_ctx) else $error("push or mask load wrong");
   property p_por_rise;
      $rose(power_on_reset_pin_b_i) |-> ##[2:6] (start_o.valid && start_o.cls == CLS_POR);
   endproperty
   a_por_rise: assert property (p_por_rise) else $error("no power-on start");
   property p_man_rise;
      $rose(manual_reset_pin_b_i) && power_on_reset_pin_b_i
         |-> ##[2:6] (start_o.valid && start_o.cls == CLS_MAN_RST);
   endproperty
   a_man_rise: assert property (p_man_rise) else $error("no manual start");
   property p_hold;
      !power_on_reset_pin_b_i [*4] |-> busy_o && !start_o.valid;
   endproperty
   a_hold: assert property (p_hold) else $error("reset pin low not holding");
   property p_after_reset;
      seq_done_i && busy_o && rst_q
         |=> vector_base_o == 32'h0 && interrupt_mask_field_o == 4'hF;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("reset end state wrong");
   property p_int_mask;
      seq_done_i && busy_o && int_q |=> interrupt_mask_field_o == lvl_q;
   endproperty
   a_int_mask: assert property (p_int_mask) else $error("level not loaded");
   property p_after_done;
      start_o.valid && start_o.cls inside {CLS_ADDR_ERR, CLS_INTERRUPT} |-> $past(exec_done_i);
   endproperty
   a_after_done: assert property (p_after_done) else $error("start before completion");
   property p_ill_time;
      start_o.valid && start_o.vec inside {8'h04, 8'h06} |-> $past(dec_valid_i);
   endproperty
   a_ill_time: assert property (p_ill_time) else $error("illegal start not at decode");

   c_por: cover property (start_o.valid && start_o.cls == CLS_POR);
   c_int: cover property (start_o.valid && start_o.cls == CLS_INTERRUPT);
   c_slot: cover property (start_o.valid && start_o.vec == 8'h06);
endmodule // eps_checker

bind eps_sequencer eps_checker chk_u (.sys_clk_i, .rst_b_i, .power_on_reset_pin_b_i,
   .manual_reset_pin_b_i, .dec_valid_i, .exec_done_i, .seq_done_i, .start_o, .ack_o,
   .vector_base_o, .interrupt_mask_field_o, .busy_o);

// ### verif/eps_pipe_model.sv
// Pipeline and requester model facing the exception sequencer.
// Assumes the bench sets requests by one-cycle pulses.
`timescale 1ns/100ps

module eps_pipe_model
   import eps_pkg::*;
(
   input wire logic sys_clk_i, // System clock
   input wire logic rst_b_i, // Async reset, active low
   input wire logic busy_i, // Sequencer busy
   input wire eps_pkg::eps_start_s start_i, // Exception start
   input wire eps_pkg::eps_ack_s ack_i, // Acknowledges
   input wire eps_pkg::eps_ack_s set_i, // New requests
   input wire logic slow_i, // Long execution and sequence
   output eps_pkg::eps_ack_s req_o, // Held requests
   output logic exec_done_o, // Instruction finished
   output logic seq_done_o // Sequence finished
);
   logic [3:0] cnt_q;
   logic run_q;

   // Held requests and timed completion pulses
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         req_o <= '0;
         cnt_q <= 4'h0;
         run_q <= 1'b0;
         exec_done_o <= 1'b0;
         seq_done_o <= 1'b0;
      end
      else
      begin
         req_o <= eps_ack_s'((req_o & ~ack_i) | set_i);
         exec_done_o <= 1'b0;
         seq_done_o <= 1'b0;
         if (!busy_i || start_i.valid)
         begin
            cnt_q <= 4'h0;
            run_q <= start_i.valid;
         end
         else
         begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == (slow_i ? 4'h9 : 4'h2))
            begin
               exec_done_o <= !run_q;
               seq_done_o <= run_q;
            end
         end
      end
endmodule // eps_pipe_model

// ### verif/tb.sv
// Self-checking bench for the exception priority sequencer.
// Assumes the pipeline model and the bound checker beside it.
`timescale 1ns/100ps
`define CHK(n, e, g) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("MISMATCH %s exp %0h got %0h", n, e, g); \
      end \
   end

module tb;
   import eps_pkg::*;
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0, power_on_reset_pin_b_i = 1'b1;
   logic manual_reset_pin_b_i = 1'b1, dec_valid_i = 1'b0, mask_wr_i = 1'b0, base_wr_i = 1'b0;
   logic exec_done_i, seq_done_i, busy_o, slow = 1'b0, hit = 1'b0;
   eps_op_e dec_op_i = OP_OTHER;
   logic [7:0] dec_imm_i = 8'h00, per_vec_i = 8'h48, imm, ev;
   logic [7:0][3:0] irq_level_i;
   logic [3:0] per_level_i = 4'h1, mask_wdata_i = 4'h0, interrupt_mask_field_o;
   logic [31:0] base_wdata_i = 32'h0, vector_base_o, sw_base = 32'h0;
   eps_ack_s set = '0, req, ack_o, pend, old, got_ack;
   eps_start_s start_o, got;
   int seed = 32'h71FD, fails = 0, compares = 0;

   eps_sequencer dut_u (.sys_clk_i, .rst_b_i, .power_on_reset_pin_b_i, .manual_reset_pin_b_i,
      .dec_valid_i, .dec_op_i, .dec_imm_i, .exec_done_i, .seq_done_i,
      .cpu_addr_err_i(req.cpu_ae), .xfer_addr_err_i(req.xfer_ae), .nmi_i(req.nmi),
      .ubreak_i(req.ubreak), .irq_i(req.irq), .irq_level_i, .per_req_i(req.per),
      .per_level_i, .per_vec_i, .mask_wr_i, .mask_wdata_i, .base_wr_i, .base_wdata_i,
      .start_o, .ack_o, .vector_base_o, .interrupt_mask_field_o, .busy_o);
   eps_pipe_model model_u (.sys_clk_i, .rst_b_i, .busy_i(busy_o), .start_i(start_o),
      .ack_i(ack_o), .set_i(set), .slow_i(slow), .req_o(req), .exec_done_o(exec_done_i),
      .seq_done_o(seq_done_i));

   // ----
   // Clock, start capture and helpers
   // ----
   initial
   begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   // Catch each start away from the active edge
   always @(negedge sys_clk_i)
      if (start_o.valid === 1'b1)
      begin
         got = start_o;
         got_ack = ack_o;
         hit = 1'b1;
      end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // One decode, or two back to back when two is set
   task automatic decode(input eps_op_e a, input eps_op_e b, input logic two,
                         input logic [7:0] im);
      dec_valid_i <= 1'b1;
      dec_op_i <= a;
      dec_imm_i <= im;
      tick();
      if (two)
      begin
         dec_op_i <= b;
         tick();
      end
      dec_valid_i <= 1'b0;
      tick();
   endtask

   task automatic wait_start(input logic [7:0] e, input logic [31:0] base);
      int k;
      for (k = 0; k < 60 && hit !== 1'b1; k++)
         tick();
      if (hit !== 1'b1)
      begin
         fails++;
         stop_test();
      end
      `CHK("vec", e, got.vec)
      `CHK("addr", base + {22'h0, e, 2'b00}, got.addr)
      for (k = 0; k < 60 && busy_o !== 1'b0; k++)
         tick();
      `CHK("busy", 1'b0, busy_o)
      hit = 1'b0;
   endtask

   task automatic unmask();
      mask_wr_i <= 1'b1;
      tick();
      mask_wr_i <= 1'b0;
      tick();
   endtask

   // Next expected vector, clearing the source served
   function automatic logic [7:0] pick(inout eps_ack_s r);
      if (r.cpu_ae) begin r.cpu_ae = 1'b0; return 8'h09; end
      if (r.xfer_ae) begin r.xfer_ae = 1'b0; return 8'h0A; end
      if (r.nmi) begin r.nmi = 1'b0; return 8'h0B; end
      if (r.ubreak) begin r.ubreak = 1'b0; return 8'h0C; end
      for (int i = 0; i < 8; i++)
         if (r.irq[i]) begin r.irq[i] = 1'b0; return 8'h40 + 8'(i); end
      r.per = 1'b0;
      return per_vec_i;
   endfunction

   // ----
   // Main sequence
   // ----
   initial
   begin
      for (int i = 0; i < 8; i++)
         irq_level_i[i] = 4'(1 + {$random(seed)} % 15);
      tick(5);
      rst_b_i <= 1'b1;
      wait_start(8'h00, 32'h0);
      `CHK("mask", 4'hF, interrupt_mask_field_o)
      `CHK("base0", 32'h0, vector_base_o)
      sw_base = 32'($random(seed)) & 32'hFFFF_F000;
      base_wdata_i <= sw_base;
      base_wr_i <= 1'b1;
      tick();
      base_wr_i <= 1'b0;
      unmask();
      `CHK("base", sw_base, vector_base_o)
      decode(OP_UNDEF, OP_OTHER, 1'b0, 8'h00);
      wait_start(8'h04, sw_base);
      // Each branch kind followed by undefined code
      for (int o = 3; o < 15; o++)
      begin
         decode(eps_op_e'(o), OP_UNDEF, 1'b1, 8'h00);
         wait_start((o < 13) ? 8'h06 : 8'h04, sw_base);
      end
      // Every opcode kind placed in a delay slot
      for (int o = 0; o < 15; o++)
      begin
         decode(OP_BRANCH, eps_op_e'(o), 1'b1, 8'h00);
         if (o > 0)
            wait_start(8'h06, sw_base);
         else
         begin
            tick(12);
            `CHK("none", 1'b0, hit)
         end
      end
      // Random request sets drained under a trap decode
      for (int t = 0; t < 30; t++)
      begin
         pend = eps_ack_s'($random(seed));
         slow <= 1'($random(seed));
         set <= pend;
         tick();
         set <= '0;
         while (pend != '0)
         begin
            old = pend;
            ev = pick(pend);
            decode(OP_TRAP, OP_OTHER, 1'b0, 8'h00);
            wait_start(ev, sw_base);
            `CHK("ack", old ^ pend, got_ack)
            unmask();
         end
         imm = 8'($random(seed));
         decode(OP_TRAP, OP_OTHER, 1'b0, imm);
         wait_start(8'h20 + {3'h0, imm[4:0]}, sw_base);
      end
      // Power-on reset in the middle of an interrupt wait
      set <= eps_ack_s'(13'h0400);
      slow <= 1'b1;
      tick();
      set <= '0;
      decode(OP_OTHER, OP_OTHER, 1'b0, 8'h00);
      power_on_reset_pin_b_i <= 1'b0;
      tick(6);
      `CHK("hold", 1'b1, busy_o)
      `CHK("nostart", 1'b0, hit)
      power_on_reset_pin_b_i <= 1'b1;
      wait_start(8'h00, 32'h0);
      `CHK("base_clr", 32'h0, vector_base_o)
      decode(OP_OTHER, OP_OTHER, 1'b0, 8'h00);
      wait_start(8'h0B, 32'h0);
      manual_reset_pin_b_i <= 1'b0;
      tick(6);
      manual_reset_pin_b_i <= 1'b1;
      wait_start(8'h02, 32'h0);
      stop_test();
   end
endmodule // tb
